/* File: rtl/ssa_pkg.sv */
// constants and carrier types for the sync serial adapter control block
package ssa_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_PRIMARY = 8'h04;
  localparam logic [7:0] ADR_SELECTED = 8'h08;

  // select field values of primary_control
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_SYNC_MODE = 2'h1;
  localparam logic [1:0] SEL_FORMAT = 2'h2;
  localparam logic [1:0] SEL_SYNC_CODE = 2'h3;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PC_SEL_HI = 7;
  localparam int PC_SEL_LO = 6;
  localparam int PC_RIE = 5;
  localparam int PC_TIE = 4;
  localparam int PC_CLR_SYNC = 3;
  localparam int PC_STRIP = 2;
  localparam int PC_TX_RST = 1;
  localparam int PC_RX_RST = 0;
  localparam int SM_CLR_UF = 3;
  localparam int SM_CLR_CTS = 2;
  localparam int SM_ONE_SYNC = 1;
  localparam int SM_EXT_SYNC = 0;
  localparam int FC_EIE = 7;
  localparam int FC_TX_SYNC = 6;
  localparam int FC_WS_HI = 5;
  localparam int FC_WS_LO = 3;
  localparam int FC_ONE_BYTE = 2;
  localparam int FC_AUX_HI = 1;
  localparam int FC_AUX_LO = 0;

  // ---------------------------------------------------------------
  // reset values and fixed codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PRIMARY_RST = 8'h03;
  localparam logic [7:0] SYNC_MODE_RST = 8'h00;
  localparam logic [7:0] FORMAT_RST = 8'h18;
  localparam logic [7:0] SYNC_CODE_RST = 8'h00;
  localparam logic [7:0] MARK_CHAR = 8'hFF;
  localparam logic [1:0] AUX_DRIVE_HIGH = 2'h0;
  localparam logic [1:0] AUX_DRIVE_LOW = 2'h2;
  localparam int FIFO_DEPTH = 3;
  localparam logic [1:0] ONE_CHAR = 2'h1;
  localparam logic [1:0] TWO_CHARS = 2'h2;

  typedef struct packed {
    logic irq;
    logic pe;
    logic ovrn;
    logic transmit_underflow_flag;
    logic cts;
    logic dcd;
    logic transmit_room_flag;
    logic receive_ready_flag;
  } ssa_status_t;

  typedef struct packed {
    logic parity_err;
    logic [7:0] data;
  } ssa_rx_entry_t;

endpackage

/* File: rtl/ssa_fifo.sv */
// small flip-flop fifo used for the receive and transmit character queues
`timescale 1ns/10ps
module ssa_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o,
  output logic [1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  localparam logic [1:0] LAST = 2'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic do_push;
  logic do_pop;

  assign full_o = count_o == 2'(DEPTH);
  assign empty_o = count_o == 2'h0;
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;
  assign data_o = mem[rd_idx];

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      count_o <= 2'h0;
    end else begin
      if (do_push) begin
        wr_idx <= (wr_idx == LAST) ? 2'h0 : wr_idx + 2'h1;
      end
      if (do_pop) begin
        rd_idx <= (rd_idx == LAST) ? 2'h0 : rd_idx + 2'h1;
      end
      count_o <= count_o + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_idx] <= data_i;
    end
  end
endmodule

/* File: rtl/ssa_serial_ctrl.sv */
// control and status registers of the synchronous serial adapter
`timescale 1ns/10ps
module ssa_serial_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cts_i,
  input wire logic dcd_i,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_is_sync_i,
  input wire logic rx_parity_err_i,
  input wire logic tx_load_i,
  output logic [7:0] tx_char_o,
  output logic tx_char_valid_o,
  output logic rx_enable_o,
  output logic tx_enable_o,
  output logic sync_clear_o,
  output logic one_sync_mode_o,
  output logic ext_sync_mode_o,
  output logic [2:0] word_format_o,
  output logic transmit_underflow_o,
  output logic aux_output_pin_o,
  output logic irq_n_o
);
  // ---------------------------------------------------------------
  // registers and declarations
  // ---------------------------------------------------------------
  logic [7:0] primary_control;
  logic [7:0] sync_mode_control;
  logic [7:0] format_interrupt_control;
  logic [7:0] sync_code;
  logic acc, wr, rd, wr_pri, wr_sm, wr_fc, wr_sc;
  logic data_rd, data_wr, status_rd;
  logic [1:0] sel_field;
  logic rx_in_reset, tx_in_reset, rx_rst_pulse, tx_rst_pulse;
  logic strip, one_byte, error_irq_enable, tx_sync;
  logic rx_push, rx_full, rx_empty, overrun_evt, rx_keep;
  logic [1:0] rx_count;
  ssa_pkg::ssa_rx_entry_t rx_in, rx_head;
  logic tx_pop, tx_full, tx_empty, uf_evt;
  logic [1:0] tx_count;
  logic [7:0] tx_head;
  logic cts_m, cts_s, cts_d, dcd_m, dcd_s, dcd_d;
  logic cts_rise, dcd_rise;
  logic cts_flag, dcd_flag, ovrn_flag, tuf_flag, armed;
  logic uf_set, clr_uf, cts_clr, pair_clear;
  logic receive_ready_flag, transmit_room_flag, pe, irq_now;
  ssa_pkg::ssa_status_t status_now;

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign sel_field = primary_control[ssa_pkg::PC_SEL_HI:ssa_pkg::PC_SEL_LO];
  assign wr_pri = wr & (wb_adr_i == ssa_pkg::ADR_PRIMARY);
  assign wr_sm = wr & (wb_adr_i == ssa_pkg::ADR_SELECTED)
                 & (sel_field == ssa_pkg::SEL_SYNC_MODE);
  assign wr_fc = wr & (wb_adr_i == ssa_pkg::ADR_SELECTED)
                 & (sel_field == ssa_pkg::SEL_FORMAT);
  assign wr_sc = wr & (wb_adr_i == ssa_pkg::ADR_SELECTED)
                 & (sel_field == ssa_pkg::SEL_SYNC_CODE);
  assign data_wr = wr & (wb_adr_i == ssa_pkg::ADR_SELECTED)
                   & (sel_field == ssa_pkg::SEL_DATA);
  assign data_rd = rd & (wb_adr_i == ssa_pkg::ADR_SELECTED)
                   & (sel_field == ssa_pkg::SEL_DATA);
  assign status_rd = rd & (wb_adr_i == ssa_pkg::ADR_STATUS);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_control <= ssa_pkg::PRIMARY_RST;
    end else if (wr_pri) begin
      primary_control <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_mode_control <= ssa_pkg::SYNC_MODE_RST;
    end else if (wr_sm) begin
      // clear strobes are not stored
      sync_mode_control <= {6'h00, wb_dat_i[ssa_pkg::SM_ONE_SYNC:ssa_pkg::SM_EXT_SYNC]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      format_interrupt_control <= ssa_pkg::FORMAT_RST;
    end else if (wr_fc) begin
      format_interrupt_control <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_code <= ssa_pkg::SYNC_CODE_RST;
    end else if (wr_sc) begin
      sync_code <= wb_dat_i[7:0];
    end
  end

  assign rx_in_reset = primary_control[ssa_pkg::PC_RX_RST];
  assign tx_in_reset = primary_control[ssa_pkg::PC_TX_RST];
  assign rx_rst_pulse = wr_pri & wb_dat_i[ssa_pkg::PC_RX_RST];
  assign tx_rst_pulse = wr_pri & wb_dat_i[ssa_pkg::PC_TX_RST];
  assign strip = primary_control[ssa_pkg::PC_STRIP];
  assign one_byte = format_interrupt_control[ssa_pkg::FC_ONE_BYTE];
  assign error_irq_enable = format_interrupt_control[ssa_pkg::FC_EIE];
  assign tx_sync = format_interrupt_control[ssa_pkg::FC_TX_SYNC];
  assign clr_uf = tx_rst_pulse | (wr_sm & wb_dat_i[ssa_pkg::SM_CLR_UF]);
  assign cts_clr = tx_rst_pulse | (wr_sm & wb_dat_i[ssa_pkg::SM_CLR_CTS]);

  // ---------------------------------------------------------------
  // receive queue
  // ---------------------------------------------------------------
  assign rx_keep = rx_char_valid_i & ~rx_in_reset
                   & ~(strip & rx_is_sync_i);
  assign rx_push = rx_keep & ~rx_full;
  assign overrun_evt = rx_keep & rx_full;
  assign rx_in = '{parity_err: rx_parity_err_i, data: rx_char_i};

  ssa_fifo #(
    .WIDTH(9),
    .DEPTH(ssa_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(rx_in_reset | rx_rst_pulse),
    .push_i(rx_push),
    .pop_i(data_rd),
    .data_i(rx_in),
    .data_o(rx_head),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );

  // ---------------------------------------------------------------
  // transmit queue, preload allowed while held in reset
  // ---------------------------------------------------------------
  assign tx_pop = tx_load_i & ~tx_in_reset & ~tx_empty;
  assign uf_evt = tx_load_i & ~tx_in_reset & tx_empty;
  assign uf_set = uf_evt & tx_sync;

  ssa_fifo #(
    .WIDTH(8),
    .DEPTH(ssa_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(tx_rst_pulse),
    .push_i(data_wr),
    .pop_i(tx_pop),
    .data_i(wb_dat_i[7:0]),
    .data_o(tx_head),
    .count_o(tx_count),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_char_o <= ssa_pkg::MARK_CHAR;
      tx_char_valid_o <= 1'b0;
    end else begin
      tx_char_valid_o <= tx_pop | uf_evt;
      if (tx_pop) begin
        tx_char_o <= tx_head;
      end else if (uf_evt) begin
        tx_char_o <= tx_sync ? sync_code : ssa_pkg::MARK_CHAR;
      end
    end
  end

  // ---------------------------------------------------------------
  // modem pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_m <= 1'b0;
      cts_s <= 1'b0;
      cts_d <= 1'b0;
      dcd_m <= 1'b0;
      dcd_s <= 1'b0;
      dcd_d <= 1'b0;
    end else begin
      cts_m <= cts_i;
      cts_s <= cts_m;
      cts_d <= cts_s;
      dcd_m <= dcd_i;
      dcd_s <= dcd_m;
      dcd_d <= dcd_s;
    end
  end

  assign cts_rise = cts_s & ~cts_d;
  assign dcd_rise = dcd_s & ~dcd_d;
  assign pair_clear = rx_rst_pulse | (data_rd & armed);

  // ---------------------------------------------------------------
  // sticky flags, a set in the clearing cycle wins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || data_rd || rx_rst_pulse) begin
      armed <= 1'b0;
    end else if (status_rd) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovrn_flag <= 1'b0;
    end else if (overrun_evt) begin
      ovrn_flag <= 1'b1;
    end else if (pair_clear) begin
      ovrn_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcd_flag <= 1'b0;
    end else if (dcd_rise) begin
      dcd_flag <= 1'b1;
    end else if (pair_clear) begin
      dcd_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tuf_flag <= 1'b0;
    end else if (uf_set) begin
      tuf_flag <= 1'b1;
    end else if (clr_uf) begin
      tuf_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_flag <= 1'b0;
    end else if (cts_rise) begin
      cts_flag <= 1'b1;
    end else if (cts_clr) begin
      cts_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status and interrupt
  // ---------------------------------------------------------------
  assign receive_ready_flag = rx_count >= (one_byte ? ssa_pkg::ONE_CHAR : ssa_pkg::TWO_CHARS);
  // room depends on free slots, inhibited by reset, and by cts unless ext sync mode is set
  assign transmit_room_flag = ~tx_in_reset
                & ~(cts_s & ~sync_mode_control[ssa_pkg::SM_EXT_SYNC])
                & ((2'(ssa_pkg::FIFO_DEPTH) - tx_count)
                   >= (one_byte ? ssa_pkg::ONE_CHAR : ssa_pkg::TWO_CHARS));
  assign pe = rx_head.parity_err & ~rx_empty;
  assign irq_now = (primary_control[ssa_pkg::PC_RIE] & receive_ready_flag)
                   | (primary_control[ssa_pkg::PC_TIE] & transmit_room_flag)
                   | (error_irq_enable & (pe | ovrn_flag | tuf_flag
                             | cts_flag | dcd_flag));

  always_comb begin
    status_now.irq = ~irq_n_o;
    status_now.pe = pe;
    status_now.ovrn = ovrn_flag;
    status_now.transmit_underflow_flag = tuf_flag;
    status_now.cts = cts_flag | cts_s;
    status_now.dcd = dcd_flag | dcd_s;
    status_now.transmit_room_flag = transmit_room_flag;
    status_now.receive_ready_flag = receive_ready_flag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= ~irq_now;
    end
  end

  // ---------------------------------------------------------------
  // bus answer, unmapped reads return zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        case (wb_adr_i)
          ssa_pkg::ADR_STATUS: wb_dat_o[7:0] <= status_now;
          ssa_pkg::ADR_PRIMARY: wb_dat_o[7:0] <= primary_control;
          ssa_pkg::ADR_SELECTED: begin
            case (sel_field)
              ssa_pkg::SEL_DATA: wb_dat_o[7:0] <= rx_head.data;
              ssa_pkg::SEL_SYNC_MODE: wb_dat_o[7:0] <= sync_mode_control;
              ssa_pkg::SEL_FORMAT: wb_dat_o[7:0] <= format_interrupt_control;
              default: wb_dat_o[7:0] <= sync_code;
            endcase
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs toward the serial engine and pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
      sync_clear_o <= 1'b0;
      one_sync_mode_o <= 1'b0;
      ext_sync_mode_o <= 1'b0;
      word_format_o <= ssa_pkg::FORMAT_RST[ssa_pkg::FC_WS_HI:ssa_pkg::FC_WS_LO];
      transmit_underflow_o <= 1'b0;
    end else begin
      rx_enable_o <= ~rx_in_reset;
      tx_enable_o <= ~tx_in_reset;
      sync_clear_o <= primary_control[ssa_pkg::PC_CLR_SYNC];
      one_sync_mode_o <= sync_mode_control[ssa_pkg::SM_ONE_SYNC];
      ext_sync_mode_o <= sync_mode_control[ssa_pkg::SM_EXT_SYNC];
      word_format_o <= format_interrupt_control[ssa_pkg::FC_WS_HI:ssa_pkg::FC_WS_LO];
      transmit_underflow_o <= tuf_flag & tx_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_output_pin_o <= 1'b1;
    end else begin
      case (format_interrupt_control[ssa_pkg::FC_AUX_HI:ssa_pkg::FC_AUX_LO])
        ssa_pkg::AUX_DRIVE_HIGH: aux_output_pin_o <= 1'b1;
        ssa_pkg::AUX_DRIVE_LOW: aux_output_pin_o <= 1'b0;
        default: aux_output_pin_o <= aux_output_pin_o;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ovrn_clear_a: assert property (
    (pair_clear && !overrun_evt) |=> !ovrn_flag)
    else $error("overrun flag not cleared");
  tuf_clear_a: assert property (
    (clr_uf && !uf_set) |=> !tuf_flag ##1 !transmit_underflow_o)
    else $error("underflow flag not cleared");
  cts_clear_a: assert property (
    (cts_clr && !cts_rise) |=> !cts_flag)
    else $error("cts flag not cleared");
  room_drop_a: assert property (
    (data_wr && !tx_pop && one_byte && tx_count == ssa_pkg::TWO_CHARS) |=> !transmit_room_flag)
    else $error("room flag stayed after fill");
  ready_drop_a: assert property (
    (data_rd && !rx_push && one_byte && rx_count == ssa_pkg::ONE_CHAR) |=> !receive_ready_flag)
    else $error("ready flag stayed after read");
  select_route_a: assert property (
    wr_sm |=> sync_mode_control[ssa_pkg::SM_ONE_SYNC:ssa_pkg::SM_EXT_SYNC]
              == $past(wb_dat_i[ssa_pkg::SM_ONE_SYNC:ssa_pkg::SM_EXT_SYNC]))
    else $error("selected register not written");
  rx_irq_a: assert property (
    (primary_control[ssa_pkg::PC_RIE] && receive_ready_flag) |=> !irq_n_o)
    else $error("receive interrupt missing");
  tx_irq_a: assert property (
    (primary_control[ssa_pkg::PC_TIE] && transmit_room_flag) |=> !irq_n_o)
    else $error("transmit interrupt missing");
  strip_sync_a: assert property (
    (rx_char_valid_i && rx_is_sync_i && strip) |-> !rx_push)
    else $error("sync code not stripped");
  tx_hold_a: assert property (
    tx_in_reset |-> !tx_pop && !transmit_room_flag ##1 !tx_char_valid_o)
    else $error("transmitter active in reset");
  rx_hold_a: assert property (
    rx_in_reset |=> rx_count == 2'h0)
    else $error("receiver active in reset");
  err_irq_a: assert property (
    (error_irq_enable && ovrn_flag) |=> !irq_n_o)
    else $error("error interrupt missing");
  mark_fill_a: assert property (
    (uf_evt && !tx_sync) |=> tx_char_valid_o && tx_char_o == ssa_pkg::MARK_CHAR)
    else $error("underflow did not send mark");
  aux_low_a: assert property (
    (format_interrupt_control[ssa_pkg::FC_AUX_HI:ssa_pkg::FC_AUX_LO]
     == ssa_pkg::AUX_DRIVE_LOW) |=> !aux_output_pin_o)
    else $error("aux pin not driven low");
  irq_mirror_a: assert property (
    status_rd |=> wb_dat_o[7] == $past(~irq_n_o))
    else $error("status irq bit differs");

  overrun_seen_c: cover property (overrun_evt);
  underflow_seen_c: cover property (uf_set ##[1:20] clr_uf);
  cts_seen_c: cover property (cts_rise ##[1:20] cts_clr);
  pair_clear_c: cover property (status_rd ##[1:20] data_rd);
endmodule

/* File: testbench/ssa_engine_model.sv */
// serial engine and modem pin model facing the control block
`timescale 1ns/10ps
module ssa_engine_model (
  input wire logic clk_i,
  input wire logic [7:0] tx_char_i,
  input wire logic tx_valid_i,
  output logic cts_o,
  output logic dcd_o,
  output logic char_valid_o,
  output logic [7:0] char_o,
  output logic is_sync_o,
  output logic perr_o,
  output logic load_o
);
  initial begin
    cts_o = 1'b0;
    dcd_o = 1'b0;
    char_valid_o = 1'b0;
    char_o = 8'h00;
    is_sync_o = 1'b0;
    perr_o = 1'b0;
    load_o = 1'b0;
  end
  // one character; lines inverted once the pulse is over
  task automatic send(input logic [7:0] c, input logic s);
    char_valid_o <= 1'b1;
    char_o <= c;
    is_sync_o <= s;
    @(posedge clk_i);
    char_valid_o <= 1'b0;
    char_o <= ~c;
    is_sync_o <= ~s;
    @(posedge clk_i);
  endtask
  // ask for the next character, answer comes one cycle later
  task automatic pull(output logic [7:0] c, output logic v);
    load_o <= 1'b1;
    @(posedge clk_i);
    load_o <= 1'b0;
    @(posedge clk_i);
    v = tx_valid_i;
    c = tx_char_i;
  endtask
  // modem pin levels, held long enough for the two-flop input path
  task automatic pins(input logic c, input logic d);
    cts_o <= c;
    dcd_o <= d;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the serial adapter control block
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack, cts, dcd, rxv, rxs, rxp, load, txv;
  logic [7:0] rxc, txc;
  logic rx_en, tx_en, sclr, one_s, ext_s, tuf_o, aux, irq_n;
  logic [2:0] wf;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] c;
  logic v;

  always #2.5 clk_i = ~clk_i;

  ssa_serial_ctrl ssa_serial_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .cts_i(cts), .dcd_i(dcd), .rx_char_valid_i(rxv),
    .rx_char_i(rxc), .rx_is_sync_i(rxs), .rx_parity_err_i(rxp), .tx_load_i(load),
    .tx_char_o(txc), .tx_char_valid_o(txv), .rx_enable_o(rx_en), .tx_enable_o(tx_en),
    .sync_clear_o(sclr), .one_sync_mode_o(one_s), .ext_sync_mode_o(ext_s),
    .word_format_o(wf), .transmit_underflow_o(tuf_o), .aux_output_pin_o(aux),
    .irq_n_o(irq_n));

  ssa_engine_model ssa_engine_model_i (.clk_i(clk_i), .tx_char_i(txc), .tx_valid_i(txv),
    .cts_o(cts), .dcd_o(dcd), .char_valid_o(rxv), .char_o(rxc), .is_sync_o(rxs),
    .perr_o(rxp), .load_o(load));

  // ---------------------------------------------------------------
  // bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h00_0000, d};
    sel <= 4'h1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk({rx_en, tx_en, aux, irq_n, 1'b0, wf}, 8'h33);
    rd(8'h04, 8'h03);
    rd(8'h00, 8'h00);
    rd(8'h0c, 8'h00);
  endtask
  task automatic t_tx;
    wr(8'h04, 8'h00);
    chk({6'h00, rx_en, tx_en}, 8'h03);
    rd(8'h00, 8'h02);
    wr(8'h08, 8'hA5);
    rd(8'h00, 8'h02);
    wr(8'h08, 8'h5A);
    rd(8'h00, 8'h00);
    ssa_engine_model_i.pull(c, v);
    chk({v, c[6:0]}, 8'hA5);
    rd(8'h00, 8'h02);
    ssa_engine_model_i.pull(c, v);
    chk(c, 8'h5A);
  endtask
  task automatic t_uf;
    wr(8'h04, 8'hC0);
    wr(8'h08, 8'h16);
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h58);
    ssa_engine_model_i.pull(c, v);
    chk(c, 8'h16);
    @(posedge clk_i);
    chk({7'h00, tuf_o}, 8'h01);
    rd(8'h00, 8'h12);
    wr(8'h04, 8'h40);
    wr(8'h08, 8'h08);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h18);
    ssa_engine_model_i.pull(c, v);
    chk(c, 8'hFF);
    rd(8'h00, 8'h02);
  endtask
  task automatic t_rx;
    wr(8'h04, 8'h20);
    ssa_engine_model_i.send(8'h31, 1'b0);
    rd(8'h00, 8'h02);
    ssa_engine_model_i.send(8'h32, 1'b0);
    rd(8'h00, 8'h83);
    chk({7'h00, irq_n}, 8'h00);
    ssa_engine_model_i.send(8'h33, 1'b0);
    ssa_engine_model_i.send(8'h34, 1'b0);
    rd(8'h00, 8'hA3);
    rd(8'h08, 8'h31);
    rd(8'h00, 8'h83);
    rd(8'h08, 8'h32);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'hA0);
    wr(8'h08, 8'h1C);
    rd(8'h00, 8'h83);
    wr(8'h04, 8'h01);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h04);
    ssa_engine_model_i.send(8'h16, 1'b1);
    rd(8'h00, 8'h02);
    ssa_engine_model_i.send(8'h44, 1'b0);
    rd(8'h00, 8'h03);
    rd(8'h08, 8'h44);
  endtask
  task automatic t_modes;
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h2A);
    chk({4'h0, aux, wf}, 8'h05);
    wr(8'h08, 8'h19);
    chk({4'h0, aux, wf}, 8'h03);
    wr(8'h08, 8'h18);
    chk({4'h0, aux, wf}, 8'h0B);
    wr(8'h04, 8'h48);
    wr(8'h08, 8'h03);
    chk({5'h00, sclr, one_s, ext_s}, 8'h07);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h40);
    chk({5'h00, sclr, one_s, ext_s}, 8'h00);
  endtask
  task automatic t_pins;
    ssa_engine_model_i.pins(1'b1, 1'b1);
    rd(8'h00, 8'h0C);
    ssa_engine_model_i.pins(1'b0, 1'b0);
    rd(8'h00, 8'h0E);
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h98);
    chk({7'h00, irq_n}, 8'h00);
    wr(8'h04, 8'h40);
    wr(8'h08, 8'h04);
    rd(8'h00, 8'h86);
    ssa_engine_model_i.send(8'h55, 1'b0);
    wr(8'h04, 8'h00);
    rd(8'h08, 8'h55);
    rd(8'h00, 8'h02);
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h1C);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h61);
    wr(8'h08, 8'h62);
    rd(8'h00, 8'h02);
    wr(8'h08, 8'h63);
    rd(8'h00, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_tx;
    t_uf;
    t_rx;
    t_modes;
    t_pins;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test;
  end
endmodule
